// file: core/instr_exec.v
// decode and execute unit of the 8-bit controller with 12-bit instructions
//
// How it works
// - byte ops: destination bit 0 writes work register, 1 writes file register
// - byte ops: opcode 11:6, destination bit 5, file address 4:0
// - bit ops: opcode 11:8, bit position 7:5, file address 4:0
// - literal and control ops: opcode 11:8, 8-bit literal 7:0
// - long jump: opcode 11:9, 9-bit target 8:0
// - flag updates touch only carry bit 2, digit carry bit 1, zero bit 0
// - add: work plus file to destination, updates carry, digit carry, zero
// - subtract: file minus work in one cycle, updates carry, digit carry, zero
// - and/or/xor with file: one cycle, selected destination, zero flag only
// - and/or/xor with literal: result to work register, zero flag only
// - rotates shift one bit through carry, change carry only
// - test low skip: skip when bit is 0, one or two cycles, no flags
// - test high skip: skip when bit is 1, one or two cycles, no flags
// - decrement/increment skip: write result, skip when zero, no flags
// - long jump always takes two cycles, fetched word is dropped
// - return with literal: literal to work, pc from stack top, 2 cycles
// - watchdog restart: one cycle pulse, no flag change
// - load direction register: copy work into chosen direction register
// - load literal to work: one cycle, no flag change
// - long jump: 9-bit target to pc 8:0, pc 10:9 from status 6:5
// - taken skip discards fetched word and runs a no-operation cycle

`include "core_regs.vh"

module instr_exec #(
	parameter PC_W = 9,
	parameter STACK_DEPTH = 8,
	parameter SP_W = 3
) (
	input wire clk_sys,
	input wire sys_rst,
	input wire [11:0] prog_data,
	output reg [PC_W-1:0] prog_addr,
	output reg [7:0] work_reg,
	output reg [7:0] status_reg,
	output reg [7:0] dir_a,
	output reg [7:0] dir_b,
	output reg [7:0] dir_c,
	output reg watchdog_clear,
	output reg file_wr_en,
	output reg [4:0] file_wr_addr,
	output reg [7:0] file_wr_data,
	output reg discard_cycle
);

	////////////////////////////////////////////////////////////////////////
	// storage

	// data file, return stack and its pointer; the status byte sits at its own
	// address outside this array so flag updates need no second write port
	reg [7:0] file_mem [0:31];
	reg [PC_W-1:0] stack_mem [0:STACK_DEPTH-1];
	reg [SP_W-1:0] stack_ptr;

	// reset vector is kept at the widest counter size and cut to this variant
	localparam [10:0] reset_pc_full = `RST_PC;

	// one-hot bit mask, shared by the bit set, clear and test paths
	function [7:0] bit_mask;
		input [2:0] pos;
		begin
			bit_mask = 8'h01 << pos;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// field split

	wire [5:0] op6 = prog_data[`OP6_HI:`OP6_LO];
	wire dest_file = prog_data[`DEST_BIT];
	wire [4:0] faddr = prog_data[`FILE_HI:`FILE_LO];
	wire [3:0] op4 = prog_data[`OP4_HI:`OP4_LO];
	wire [2:0] bpos = prog_data[`BITPOS_HI:`BITPOS_LO];
	wire [7:0] lit = prog_data[`LIT_HI:`LIT_LO];
	wire [2:0] op3 = prog_data[`OP3_HI:`OP3_LO];
	wire [8:0] jlit = prog_data[`JMP_HI:`JMP_LO];
	wire [7:0] mask = bit_mask(bpos);

	// status lives in the file space, so reads see the live flags
	wire [7:0] fval = (faddr == `STATUS_ADDR) ? status_reg : file_mem[faddr];

	// wide targets, cut down to the program counter width
	wire [10:0] jump_full = {status_reg[`PAGE_HI:`PAGE_LO], jlit};
	wire [10:0] call_full = {status_reg[`PAGE_HI:`PAGE_LO], 1'b0, lit};

	// adder and subtractor with nibble carries
	wire [8:0] sum9 = {1'b0, work_reg} + {1'b0, fval};
	wire [4:0] sum_lo = {1'b0, work_reg[3:0]} + {1'b0, fval[3:0]};
	wire [8:0] dif9 = {1'b0, fval} - {1'b0, work_reg};
	wire [4:0] dif_lo = {1'b0, fval[3:0]} - {1'b0, work_reg[3:0]};

	// plain increment and decrement, shared with the skip-on-zero variants
	wire [7:0] inc8 = fval + 8'h01;
	wire [7:0] dec8 = fval - 8'h01;

	////////////////////////////////////////////////////////////////////////
	// execute decode

	// decode outputs, all set by the single combinational pass below
	reg [7:0] result;
	reg wr_w;
	reg wr_f;
	reg [2:0] flag_we;
	reg [2:0] flag_val;
	reg skip;
	reg jump;
	reg [PC_W-1:0] target;
	reg push;
	reg pop;
	reg wdt;
	reg [2:0] dir_we;

	// one combinational pass per instruction; a discarded word decodes as no-op
	always @* begin
		result = 8'h00;
		wr_w = 1'b0;
		wr_f = 1'b0;
		flag_we = 3'b000;
		flag_val = 3'b000;
		skip = 1'b0;
		jump = 1'b0;
		target = prog_addr;
		push = 1'b0;
		pop = 1'b0;
		wdt = 1'b0;
		dir_we = 3'b000;
		if (!discard_cycle) begin
			if (op3 == `OP_JUMP) begin
				jump = 1'b1;
				target = jump_full[PC_W-1:0];
			end else if (op4[3]) begin
				case (op4)
					`OP_RETL: begin
						result = lit;
						wr_w = 1'b1;
						pop = 1'b1;
						jump = 1'b1;
						target = stack_mem[stack_ptr - 1'b1];
					end
					`OP_CALL: begin
						push = 1'b1;
						jump = 1'b1;
						target = call_full[PC_W-1:0];
					end
					`OP_MOVL: begin
						result = lit;
						wr_w = 1'b1;
					end
					`OP_IORL, `OP_ANDL, `OP_XORL: begin
						if (op4 == `OP_IORL)
							result = work_reg | lit;
						else if (op4 == `OP_ANDL)
							result = work_reg & lit;
						else
							result = work_reg ^ lit;
						wr_w = 1'b1;
						flag_we = 3'b001;
						flag_val = {2'b00, result == 8'h00};
					end
					default: begin
						result = 8'h00; // unused literal slots act as no-op
					end
				endcase
			end else if (op4[2]) begin
				case (op4)
					`OP_BCLR: begin
						result = fval & ~mask;
						wr_f = 1'b1;
					end
					`OP_BSET: begin
						result = fval | mask;
						wr_f = 1'b1;
					end
					`OP_BTSC: begin
						skip = ((fval & mask) == 8'h00);
					end
					default: begin
						skip = ((fval & mask) != 8'h00);
					end
				endcase
			end else begin
				case (op6)
					`OP_MISC: begin
						if (dest_file) begin
							result = work_reg; // store work to file
							wr_f = 1'b1;
						end else if (prog_data[5:0] == `MISC_WDT) begin
							wdt = 1'b1;
						end else if (prog_data[5:3] == 3'b000 && prog_data[2:0] >= 3'd5) begin
							// codes 5 to 7 pick a port; codes 0 to 3 stay no-ops
							dir_we = 3'b001 << (prog_data[2:0] - 3'd5);
						end
					end
					`OP_CLR: begin
						result = 8'h00;
						wr_w = ~dest_file;
						wr_f = dest_file;
						flag_we = 3'b001;
						flag_val = 3'b001;
					end
					`OP_ADD: begin
						result = sum9[7:0];
						flag_we = 3'b111;
						flag_val = {sum9[8], sum_lo[4], sum9[7:0] == 8'h00};
					end
					`OP_SUB: begin
						result = dif9[7:0];
						flag_we = 3'b111;
						flag_val = {~dif9[8], ~dif_lo[4], dif9[7:0] == 8'h00};
					end
					`OP_IOR, `OP_AND, `OP_XOR: begin
						if (op6 == `OP_IOR)
							result = work_reg | fval;
						else if (op6 == `OP_AND)
							result = work_reg & fval;
						else
							result = work_reg ^ fval;
						flag_we = 3'b001;
						flag_val = {2'b00, result == 8'h00};
					end
					`OP_MOVE_FILE, `OP_COM, `OP_INC, `OP_DEC: begin
						if (op6 == `OP_MOVE_FILE)
							result = fval;
						else if (op6 == `OP_COM)
							result = ~fval;
						else if (op6 == `OP_INC)
							result = inc8;
						else
							result = dec8;
						flag_we = 3'b001;
						flag_val = {2'b00, result == 8'h00};
					end
					`OP_INCSZ, `OP_DECSZ: begin
						result = (op6 == `OP_INCSZ) ? inc8 : dec8;
						skip = (result == 8'h00);
					end
					`OP_RLF: begin
						result = {fval[6:0], status_reg[`FLAG_C]};
						flag_we = 3'b100;
						flag_val = {fval[7], 2'b00};
					end
					`OP_RRF: begin
						result = {status_reg[`FLAG_C], fval[7:1]};
						flag_we = 3'b100;
						flag_val = {fval[0], 2'b00};
					end
					default: begin
						result = {fval[3:0], fval[7:4]}; // nibble swap
					end
				endcase
				// byte ops past the misc and clear groups obey the destination bit
				if (op6 != `OP_MISC && op6 != `OP_CLR) begin
					wr_w = ~dest_file;
					wr_f = dest_file;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// program counter, stack and discard

	// a jump or a taken skip turns the already fetched word into a no-op
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			prog_addr <= reset_pc_full[PC_W-1:0];
			stack_ptr <= {SP_W{1'b0}};
			discard_cycle <= 1'b1; // nothing fetched yet
		end else begin
			prog_addr <= jump ? target : prog_addr + 1'b1;
			discard_cycle <= jump | skip;
			// stack overflow is not trapped; the ninth nested call loses the first return
			if (push) begin
				stack_mem[stack_ptr] <= prog_addr;
				stack_ptr <= stack_ptr + 1'b1;
			end else if (pop) begin
				stack_ptr <= stack_ptr - 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// working register, status and file space

	// flags are merged after a file write so an explicit status write
	// keeps its upper bits while the flag update still lands
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			work_reg <= `RST_W;
			status_reg <= `RST_STATUS;
			file_wr_en <= 1'b0;
			file_wr_addr <= 5'h00;
			file_wr_data <= 8'h00;
			watchdog_clear <= 1'b0;
		end else begin
			if (wr_w)
				work_reg <= result;
			if (wr_f && faddr == `STATUS_ADDR)
				status_reg <= {result[7:3], flag_we[2] ? flag_val[2] : result[2],
					flag_we[1] ? flag_val[1] : result[1], flag_we[0] ? flag_val[0] : result[0]};
			else
				status_reg <= {status_reg[7:3], (flag_we & flag_val) | (~flag_we & status_reg[2:0])};
			if (wr_f && faddr != `STATUS_ADDR)
				file_mem[faddr] <= result;
			// the write port mirrors every file write, status included, for the far side
			file_wr_en <= wr_f;
			file_wr_addr <= faddr;
			file_wr_data <= result;
			watchdog_clear <= wdt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// port direction registers

	// three identical registers, one per port, all loaded from the work register
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_dir
			reg [7:0] dir_q;
			always @(posedge clk_sys) begin
				if (sys_rst)
					dir_q <= `RST_DIR;
				else if (dir_we[gi])
					dir_q <= work_reg;
			end
		end
	endgenerate

	// direction outputs taken straight from the generated flops
	always @* begin
		dir_a = g_dir[0].dir_q;
		dir_b = g_dir[1].dir_q;
		dir_c = g_dir[2].dir_q;
	end

endmodule

// file: include/core_regs.vh
// constants for the 12-bit instruction decode and execute unit
`ifndef CORE_REGS_VH
`define CORE_REGS_VH

// instruction field positions
`define OP6_HI 11
`define OP6_LO 6
`define DEST_BIT 5
`define FILE_HI 4
`define FILE_LO 0
`define OP4_HI 11
`define OP4_LO 8
`define BITPOS_HI 7
`define BITPOS_LO 5
`define LIT_HI 7
`define LIT_LO 0
`define OP3_HI 11
`define OP3_LO 9
`define JMP_HI 8
`define JMP_LO 0

// status flag positions and page bits
`define FLAG_C 2
`define FLAG_DC 1
`define FLAG_Z 0
`define PAGE_HI 6
`define PAGE_LO 5

// file address of the status register
`define STATUS_ADDR 5'h03

// byte-oriented opcodes, bits 11:6
`define OP_MISC 6'h00
`define OP_CLR 6'h01
`define OP_SUB 6'h02
`define OP_DEC 6'h03
`define OP_IOR 6'h04
`define OP_AND 6'h05
`define OP_XOR 6'h06
`define OP_ADD 6'h07
`define OP_MOVE_FILE 6'h08
`define OP_COM 6'h09
`define OP_INC 6'h0a
`define OP_DECSZ 6'h0b
`define OP_RRF 6'h0c
`define OP_RLF 6'h0d
`define OP_SWAP 6'h0e
`define OP_INCSZ 6'h0f

// bit-oriented and literal opcodes, bits 11:8; long jump opcode, bits 11:9
`define OP_BCLR 4'h4
`define OP_BSET 4'h5
`define OP_BTSC 4'h6
`define OP_BTSS 4'h7
`define OP_RETL 4'h8
`define OP_CALL 4'h9
`define OP_MOVL 4'hc
`define OP_IORL 4'hd
`define OP_ANDL 4'he
`define OP_XORL 4'hf
`define OP_JUMP 3'h5

// special words in the misc group, low 6 bits
`define MISC_NOP 6'h00
`define MISC_WDT 6'h04

// reset values
`define RST_W 8'h00
`define RST_STATUS 8'h18
`define RST_DIR 8'hff
`define RST_PC 11'h000

`endif

// file: test/instr_exec_properties.sv
// concurrent checks on the ports of the execute unit
module instr_exec_props #(
	parameter PC_W = 9
) (
	input logic clk_sys,
	input logic sys_rst,
	input logic [11:0] prog_data,
	input logic [PC_W-1:0] prog_addr,
	input logic [7:0] work_reg,
	input logic [7:0] status_reg,
	input logic [7:0] dir_a,
	input logic [7:0] dir_b,
	input logic [7:0] dir_c,
	input logic watchdog_clear,
	input logic file_wr_en,
	input logic [4:0] file_wr_addr,
	input logic [7:0] file_wr_data,
	input logic discard_cycle
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// a word only counts when the fetch slot was not dropped
	wire run = !discard_cycle;
	wire [3:0] op = prog_data[11:8];
	a_jump_target: assert property (
		run && prog_data[11:9] == 3'h5 |=> discard_cycle && prog_addr[8:0] == $past(prog_data[8:0]))
		else $error("jump target wrong");
	a_call_target: assert property (
		run && op == 4'h9 |=> discard_cycle && prog_addr[8:0] == {1'b0, $past(prog_data[7:0])})
		else $error("call target wrong");
	a_literal_load: assert property (
		run && op == 4'hc |=> work_reg == $past(prog_data[7:0]) && $stable(status_reg))
		else $error("literal load wrong");
	a_return_literal: assert property (
		run && op == 4'h8 |=> discard_cycle && work_reg == $past(prog_data[7:0]))
		else $error("return literal wrong");
	a_watchdog_pulse: assert property (
		run && prog_data == 12'h004 |=> watchdog_clear && $stable(status_reg))
		else $error("watchdog pulse missing");
	a_bit_force: assert property (
		run && prog_data[11:9] == 3'h2 |=> file_wr_en && file_wr_addr == $past(prog_data[4:0])
		&& file_wr_data[$past(prog_data[7:5])] == $past(prog_data[8]))
		else $error("bit force wrong");
	a_clear_work: assert property (
		run && prog_data == 12'h040 |=> work_reg == 8'h00 && status_reg[0])
		else $error("clear work wrong");
	a_upper_status: assert property (
		!(file_wr_en && file_wr_addr == 5'h03) |-> $stable(status_reg[7:3]))
		else $error("upper status moved");
	a_literal_zero: assert property (
		run && op >= 4'hd |=> status_reg[0] == (work_reg == 8'h00)
		&& status_reg[2:1] == $past(status_reg[2:1]))
		else $error("literal logic flags wrong");
	a_add_flags: assert property (
		run && prog_data[11:5] == 7'h0f |=> file_wr_en
		&& status_reg[2] == (file_wr_data < $past(work_reg))
		&& status_reg[1] == (file_wr_data[3:0] < $past(work_reg[3:0]))
		&& status_reg[0] == (file_wr_data == 8'h00))
		else $error("add flags wrong");
	a_sub_flags: assert property (
		run && prog_data[11:5] == 7'h04 |=> status_reg[0] == (work_reg == 8'h00)
		&& status_reg[2] == ({1'b0, work_reg} + {1'b0, $past(work_reg)} < 9'h100)
		&& status_reg[1] == ({1'b0, work_reg[3:0]} + {1'b0, $past(work_reg[3:0])} < 5'h10))
		else $error("subtract flags wrong");
	c_skip: cover property (run && op == 4'h6 ##1 discard_cycle);
	c_call: cover property (run && op == 4'h9);
	c_marker: cover property (watchdog_clear);
endmodule
////////////////////////////////////////
bind instr_exec instr_exec_props #(.PC_W(PC_W)) props_i (.clk_sys(clk_sys),
	.sys_rst(sys_rst), .prog_data(prog_data), .prog_addr(prog_addr), .work_reg(work_reg),
	.status_reg(status_reg), .dir_a(dir_a), .dir_b(dir_b), .dir_c(dir_c),
	.watchdog_clear(watchdog_clear), .file_wr_en(file_wr_en), .file_wr_addr(file_wr_addr),
	.file_wr_data(file_wr_data), .discard_cycle(discard_cycle));

// file: test/prog_rom.sv
// synchronous program memory model feeding the execute unit
module prog_rom #(
	parameter AW = 9
) (
	input logic clk_sys,
	input logic [AW-1:0] prog_addr,
	output logic [11:0] prog_data = 12'h000
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [11:0] mem [0:(1<<AW)-1];
	// one cycle of read latency, so a fetch slot always lags the address
	always @(posedge clk_sys) begin
		prog_data <= mem[prog_addr];
	end
endmodule

// file: test/tb.sv
// self-checking bench running a short program through the execute unit
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	wire [11:0] prog_data;
	wire [8:0] prog_addr;
	wire [7:0] work_reg, status_reg, dir_a, dir_b, dir_c, file_wr_data;
	wire [4:0] file_wr_addr;
	wire watchdog_clear, file_wr_en, discard_cycle;
	int fails = 0, num_checks = 0, cyc = 0, nw = 0, np = 0, last = 0;
	localparam logic [11:0] p0 [23] = '{12'hc0f, 12'h030, 12'hcf1, 12'h1f0, 12'h090, 12'h1b0,
		12'h330, 12'h350, 12'h004, 12'h770, 12'h670, 12'hcee, 12'h004, 12'h5f0, 12'h410,
		12'h3f0, 12'he08, 12'hf08, 12'hd30, 12'h006, 12'h940, 12'h004, 12'ha50};
	localparam logic [11:0] p1 [7] = '{12'h071, 12'h0f1, 12'h3f1, 12'hcee, 12'h004, 12'h040,
		12'ha56};
	localparam logic [15:0] exp_wr [10] = '{16'h100f, 16'h1000, 16'h100f, 16'h1007, 16'h1087,
		16'h1086, 16'h1087, 16'h1100, 16'h11ff, 16'h1100};
	localparam logic [15:0] exp_mk [4] = '{16'h0f18, 16'h0f18, 16'h5a18, 16'h5a18};
	localparam logic [15:0] exp_gap [3] = '{16'd4, 16'd12, 16'd7};
	// expected and seen file write, packed as address over data
	wire [15:0] wr_exp = nw < 10 ? exp_wr[nw] : 16'hffff;
	wire [15:0] wr_seen = {3'h0, file_wr_addr, file_wr_data};
	always #25 clk_sys = ~clk_sys;
	instr_exec uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .prog_data(prog_data),
		.prog_addr(prog_addr), .work_reg(work_reg), .status_reg(status_reg), .dir_a(dir_a),
		.dir_b(dir_b), .dir_c(dir_c), .watchdog_clear(watchdog_clear), .file_wr_en(file_wr_en),
		.file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data), .discard_cycle(discard_cycle));
	prog_rom rom (.clk_sys(clk_sys), .prog_addr(prog_addr), .prog_data(prog_data));
	////////////////////////////////////////
	task automatic put(input int a, input logic [11:0] w);
		rom.mem[a] = w;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// score file writes and marker pulses; markers time the skips and branches
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (!sys_rst && file_wr_en) begin
			chk("file write", wr_exp, wr_seen);
			nw++;
		end
		if (!sys_rst && watchdog_clear) begin
			chk("marker state", exp_mk[np % 4], {work_reg, status_reg});
			if (np > 0) begin
				chk("marker gap", exp_gap[(np - 1) % 3], 16'(cyc - last));
			end
			last = cyc;
			np++;
		end
	end
	// main sequence: load the program, reset, run to the final loop
	initial begin
		for (int i = 0; i < 512; i++) put(i, 12'h000);
		for (int i = 0; i < 23; i++) put(i, p0[i]);
		put(9'h040, 12'h85a);
		for (int i = 0; i < 7; i++) put(9'h050 + i, p1[i]);
		repeat (4) @(posedge clk_sys);
		#1;
		chk("reset state", 16'h0018, {work_reg, status_reg});
		chk("reset dirs", 16'hffff, {dir_a, dir_b});
		chk("reset fetch", 16'h0001, {6'h0, prog_addr, discard_cycle});
		@(posedge clk_sys) sys_rst <= 1'b0;
		$display("test reset done");
		for (int i = 0; i < 100 && np < 4; i++) @(posedge clk_sys);
		repeat (3) @(posedge clk_sys);
		#1;
		chk("final work and status", 16'h0019, {work_reg, status_reg});
		chk("direction regs", 16'hff30, {dir_a, dir_b});
		chk("direction reg c", 16'h00ff, {8'h00, dir_c});
		chk("write count", 16'd10, 16'(nw));
		chk("marker count", 16'd4, 16'(np));
		$display("test program done");
		give_verdict();
	end
	// watchdog against a hung run
	initial begin
		#20000;
		fails++;
		give_verdict();
	end
endmodule
